// file: smbcc_pkg.sv
// package: register map, field positions, reset values and timing counts
// Operation
// RULE1: when enabled, the interface continuously monitors sda and scl
// RULE2: slave inhibit suppresses slave interrupts; master interrupts unaffected (the code also drops the start interrupt, raised before master_q is set)
// RULE3: busy set during a transfer, cleared on stop or bus-free timeout
// RULE4: hold-extension bit selects normal or extended sda setup and hold
// RULE5: hold 3 clocks normally; extended setup 11 and hold 12 clocks
// RULE6: scl-low timeout enable reloads timer 3 on scl high, counts low
// RULE7: in split mode only timer 3 high byte is held in reload
// RULE8: software sets timer 3 to 25 ms and resets the interface then
// RULE9: bus free after scl and sda high over 10 bit-clock periods
// RULE10: clock select picks timer0, timer1, timer2 high or low overflow
// RULE11: upper control bits report master role and transmit direction
// RULE12: start and stop flags report conditions seen since last interrupt
// RULE13: writing start enters master mode, starts when free; not auto-cleared
// RULE14: stop written as master ends transfer after the next ack cycle
// RULE15: start and stop both set as master give stop then start
// RULE16: ack write sets outgoing value; read returns last received ack
// RULE17: ack request flag set each time a byte is received
// RULE18: ack should be written before clearing interrupt, else nack sent
// RULE19: sda follows written ack at once; scl held low until flag clear
// RULE20: after a nacked slave address, ignore slave events until start
// RULE21: arbitration lost set on lost arbitration; cleared with interrupt flag
// RULE22: interrupt flag set at transfer start, end, each byte, arbitration loss
// RULE23: while interrupt flag set, interface stalls and holds scl low
// RULE24: transmitter interrupts after ack cycle, receiver before ack cycle
// RULE25: writing 0 to interrupt flag starts next event; 1 forces interrupt
package smbcc_pkg;
    localparam logic [7:0] CFG_ADDR = 8'hc1;
    localparam logic [7:0] CTL_ADDR = 8'hc0;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam int CFG_EN = 7;
    localparam int CFG_INH = 6;
    localparam int CFG_BUSY = 5;
    localparam int CFG_EXTH = 4;
    localparam int CFG_TOE = 3;
    localparam int CFG_FTE = 2;
    localparam int CFG_CS_LO = 0;
    localparam int CTL_MASTER = 7;
    localparam int CTL_TX = 6;
    localparam int CTL_STA = 5;
    localparam int CTL_STO = 4;
    localparam int CTL_ACK_REQUEST = 3;
    localparam int CTL_ARB = 2;
    localparam int CTL_ACK = 1;
    localparam int CTL_SI = 0;
    localparam int HOLD_NORM_CLK = 3;
    localparam int SETUP_EXT_CLK = 11;
    localparam int HOLD_EXT_CLK = 12;
    localparam int FREE_PERIODS = 10;
    localparam logic [1:0] CS_T0 = 2'h0;
    localparam logic [1:0] CS_T1 = 2'h1;
    localparam logic [1:0] CS_T2H = 2'h2;
    localparam logic [1:0] CS_T2L = 2'h3;
    typedef enum logic [2:0] {
        SMBCC_IDLE, SMBCC_START, SMBCC_BIT_LO, SMBCC_BIT_HI, SMBCC_WAIT,
        SMBCC_STOP
    } smbcc_state_t;
endpackage

// file: smbcc_line_if.sv
// interface: synchronised bus line levels and edges shared by the modules
`timescale 1ns/100ps
interface smbcc_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    modport src (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
    modport dst (input scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface

// file: smbcc_line_sync.sv
// module: two-flop synchroniser and condition detector for scl and sda
`timescale 1ns/100ps
module smbcc_line_sync
    import smbcc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // raw pins and enable
    input wire logic scl_pin_i,
    input wire logic sda_pin_i,
    input wire logic enable_i,
    // conditioned lines
    smbcc_line_if.src line
);
    logic [1:0] scl_s_q;
    logic [1:0] sda_s_q;
    logic scl_q;
    logic sda_q;
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], scl_pin_i};
            sda_s_q <= {sda_s_q[0], sda_pin_i};
            scl_q <= scl_s_q[1];
            sda_q <= sda_s_q[1];
        end
    end
    // edge and condition detection runs only while enabled; scl and sda levels always pass
    assign line.scl = scl_s_q[1];
    assign line.sda = sda_s_q[1];
    assign line.scl_rise = enable_i & scl_s_q[1] & ~scl_q; // RULE1
    assign line.scl_fall = enable_i & ~scl_s_q[1] & scl_q; // RULE1
    assign line.start_det = enable_i & scl_s_q[1] & scl_q
        & sda_q & ~sda_s_q[1]; // RULE1
    assign line.stop_det = enable_i & scl_s_q[1] & scl_q
        & ~sda_q & sda_s_q[1]; // RULE1
endmodule

// file: smbcc_top.sv
// module: smbus configuration, control/status and bit-level engine
`timescale 1ns/100ps
module smbcc_top
    import smbcc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // special function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    output logic [7:0] sfr_rdata_o,
    // data byte handshake with the shift register
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_loaded_i,
    input wire logic [7:0] own_addr_i,
    output logic [7:0] rx_byte_o,
    output logic rx_byte_valid_o,
    // bit clock sources
    input wire logic t0_ovf_i,
    input wire logic t1_ovf_i,
    input wire logic t2h_ovf_i,
    input wire logic t2l_ovf_i,
    // timer 3 control
    input wire logic t3_split_i,
    output logic t3_reload_o,
    output logic t3_reload_hi_o,
    // bus pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);
    logic [7:0] cfg_q;
    logic master_q, tx_q, sta_q, sto_q, ack_request_q, arb_q, ack_q, si_q;
    logic busy_q, slave_act_q, slave_ign_q, inh_eff_q;
    // start request from software only; a detected start must not launch
    logic sta_wr_q;
    smbcc_state_t st_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [3:0] free_q;
    logic [3:0] hold_q;
    logic sda_drv_q, scl_drv_q, ack_phase_q, addr_phase_q;
    logic [7:0] rx_q;
    logic rxv_q;
    smbcc_line_if line ();
    smbcc_line_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .scl_pin_i(scl_i),
        .sda_pin_i(sda_i),
        .enable_i(cfg_q[CFG_EN]),
        .line(line)
    );
    wire en = cfg_q[CFG_EN];
    wire [1:0] cs = cfg_q[CFG_CS_LO+1:CFG_CS_LO];
    // bit-rate tick selection
    wire tick = (cs == CS_T0) ? t0_ovf_i :
        (cs == CS_T1) ? t1_ovf_i :
        (cs == CS_T2H) ? t2h_ovf_i : t2l_ovf_i; // RULE10
    wire wr_cfg = sfr_wr_i & (sfr_addr_i == CFG_ADDR);
    wire wr_ctl = sfr_wr_i & (sfr_addr_i == CTL_ADDR);
    wire si_clr = wr_ctl & ~sfr_wdata_i[CTL_SI];
    wire [3:0] hold_min = cfg_q[CFG_EXTH] ? 4'(HOLD_EXT_CLK)
        : 4'(HOLD_NORM_CLK); // RULE4 RULE5
    wire [3:0] setup_min = cfg_q[CFG_EXTH] ? 4'(SETUP_EXT_CLK)
        : 4'h1; // RULE4 RULE5
    wire bus_free = cfg_q[CFG_FTE] && free_q > 4'(FREE_PERIODS); // RULE9
    wire stall = si_q; // RULE23
    // hardware interrupt events
    logic ev_si, ev_arb, ev_byte_rx, ev_ack_done;
    wire ev_slave_stop = line.stop_det & slave_act_q;
    wire slave_ok = ~inh_eff_q & ~slave_ign_q;
    // timer 3 reload steering
    assign t3_reload_o = en & cfg_q[CFG_TOE] & line.scl
        & ~t3_split_i; // RULE6
    assign t3_reload_hi_o = en & cfg_q[CFG_TOE] & line.scl; // RULE6 RULE7
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    // the flag holds scl low whenever enabled, on an idle bus as well
    assign scl_oe_o = scl_drv_q | (stall & en); // RULE23
    assign sda_oe_o = sda_drv_q;
    assign rx_byte_o = rx_q;
    assign rx_byte_valid_o = rxv_q;
    // read mux
    wire [7:0] cfg_rd = {cfg_q[7:6], busy_q, cfg_q[4:0]};
    wire [7:0] ctl_rd = {master_q, tx_q, sta_q, sto_q, ack_request_q, arb_q,
        ack_q, si_q}; // RULE11 RULE16
    always_ff @(posedge clk_sys_i) begin
        if (srst_i)
            sfr_rdata_o <= 8'h00;
        else if (sfr_rd_i)
            sfr_rdata_o <= (sfr_addr_i == CFG_ADDR) ? cfg_rd :
                (sfr_addr_i == CTL_ADDR) ? ctl_rd : 8'h00;
    end
    always_ff @(posedge clk_sys_i) begin
        if (srst_i)
            cfg_q <= CFG_RST;
        else if (wr_cfg)
            cfg_q <= {sfr_wdata_i[7:6], 1'b0, sfr_wdata_i[4:0]};
    end
    // inhibit takes effect at the next start, or at once while the bus is not busy
    always_ff @(posedge clk_sys_i) begin
        if (srst_i)
            inh_eff_q <= 1'b0;
        else if (line.start_det || !busy_q)
            inh_eff_q <= cfg_q[CFG_INH]; // RULE2
    end
    // bus free counter in bit-clock periods
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || !line.scl || !line.sda || !en)
            free_q <= 4'h0;
        else if (tick && free_q != 4'hf)
            free_q <= free_q + 4'h1; // RULE9
    end
    always_ff @(posedge clk_sys_i) begin
        if (srst_i)
            busy_q <= 1'b0;
        else if (line.start_det || st_q == SMBCC_START)
            busy_q <= 1'b1; // RULE3
        else if (line.stop_det || bus_free || !en)
            busy_q <= 1'b0; // RULE3
    end
    // control register flags: hardware set wins over software clear
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            {master_q, tx_q, sta_q, sto_q, ack_request_q, arb_q, ack_q, si_q}
                <= CTL_RST;
            sta_wr_q <= 1'b0;
        end else begin
            if (wr_ctl) begin
                sta_q <= sfr_wdata_i[CTL_STA]; // RULE13
                sta_wr_q <= sfr_wdata_i[CTL_STA]; // RULE13
                sto_q <= sfr_wdata_i[CTL_STO]; // RULE14
                ack_q <= sfr_wdata_i[CTL_ACK]; // RULE16 RULE18
                si_q <= sfr_wdata_i[CTL_SI]; // RULE25
            end
            if (si_clr)
                arb_q <= 1'b0; // RULE21
            if (line.start_det && !master_q)
                sta_q <= slave_ok; // RULE12
            if (ev_slave_stop && slave_ok)
                sto_q <= 1'b1; // RULE12
            if (st_q == SMBCC_STOP && tick && line.scl)
                sto_q <= 1'b0; // RULE14
            if (st_q == SMBCC_START && tick) begin
                master_q <= 1'b1; // RULE13
                tx_q <= 1'b1;
            end
            if (st_q == SMBCC_STOP && tick && line.scl)
                master_q <= 1'b0;
            if (ev_byte_rx) begin
                ack_request_q <= 1'b1; // RULE17
                // no ack written before the flag is cleared means nack
                ack_q <= 1'b0; // RULE18
            end
            if (ev_ack_done) begin
                ack_request_q <= 1'b0;
                if (tx_q)
                    ack_q <= ~line.sda; // RULE16
            end
            if (ev_arb) begin
                arb_q <= 1'b1; // RULE21
                master_q <= 1'b0;
                tx_q <= 1'b0;
            end
            if (line.start_det && !master_q)
                tx_q <= 1'b0;
            if (tx_loaded_i && st_q == SMBCC_WAIT)
                tx_q <= 1'b1;
            if (ev_si && (master_q || slave_ok))
                si_q <= 1'b1; // RULE2 RULE22
        end
    end
    // interrupt causes
    always_comb begin
        ev_byte_rx = 1'b0;
        ev_ack_done = 1'b0;
        ev_arb = 1'b0;
        ev_si = 1'b0;
        if (st_q == SMBCC_START && tick)
            ev_si = 1'b1; // RULE22
        if (ev_slave_stop)
            ev_si = 1'b1; // RULE22
        if (line.scl_fall && bit_q == 4'd8 && !tx_q && !ack_phase_q)
            ev_byte_rx = 1'b1; // RULE17
        if (line.scl_fall && ack_phase_q)
            ev_ack_done = 1'b1;
        if (ev_byte_rx && !tx_q)
            ev_si = 1'b1; // RULE24
        if (ev_ack_done && tx_q)
            ev_si = 1'b1; // RULE24
        if (tx_q && sda_drv_q == 1'b0 && !ack_phase_q && line.scl_rise
            && !line.sda && bit_q != 4'd0)
            ev_arb = 1'b1; // RULE21
        if (master_q && line.start_det && !sta_q)
            ev_arb = 1'b1; // RULE21
        if (ev_arb)
            ev_si = 1'b1; // RULE22
    end
    // bit engine: master generation, slave receive, ack drive
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || !en) begin
            st_q <= SMBCC_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            hold_q <= 4'h0;
            sda_drv_q <= 1'b0;
            scl_drv_q <= 1'b0;
            ack_phase_q <= 1'b0;
            addr_phase_q <= 1'b0;
            slave_act_q <= 1'b0;
            slave_ign_q <= 1'b0;
            rx_q <= 8'h00;
            rxv_q <= 1'b0;
        end else begin
            rxv_q <= 1'b0;
            if (hold_q != 4'h0)
                hold_q <= hold_q - 4'h1;
            if (line.start_det) begin
                bit_q <= 4'h0;
                addr_phase_q <= 1'b1;
                slave_ign_q <= 1'b0; // RULE20
                slave_act_q <= 1'b0;
            end
            if (line.stop_det)
                slave_act_q <= 1'b0;
            if (line.scl_rise && !ack_phase_q && bit_q < 4'd8) begin
                sh_q <= {sh_q[6:0], line.sda};
                bit_q <= bit_q + 4'h1;
            end
            if (ev_byte_rx) begin
                rx_q <= sh_q;
                rxv_q <= 1'b1;
            end
            if (line.scl_fall && bit_q == 4'd8 && !ack_phase_q) begin
                ack_phase_q <= 1'b1;
                hold_q <= hold_min; // RULE5
                if (addr_phase_q && !master_q) begin
                    if (sh_q[7:1] == own_addr_i[7:1] && slave_ok)
                        slave_act_q <= 1'b1;
                    else
                        slave_ign_q <= 1'b1; // RULE20
                end
            end
            // drive written ack value as receiver once hold is met
            if (ack_phase_q && !tx_q && hold_q == 4'h0)
                sda_drv_q <= ack_q; // RULE18 RULE19
            if (ev_ack_done) begin
                ack_phase_q <= 1'b0;
                addr_phase_q <= 1'b0;
                bit_q <= 4'h0;
                hold_q <= hold_min; // RULE5
            end
            if (ack_phase_q && hold_q == 4'h0 && line.scl_fall)
                sda_drv_q <= 1'b0;
            // master clock and condition generation, stalled by si
            case (st_q)
                SMBCC_IDLE: begin
                    scl_drv_q <= 1'b0;
                    if (sta_wr_q && !stall && (!busy_q || bus_free))
                        st_q <= SMBCC_START; // RULE13
                end
                SMBCC_START: begin
                    sda_drv_q <= 1'b1;
                    if (tick)
                        st_q <= SMBCC_WAIT;
                end
                SMBCC_WAIT: begin
                    scl_drv_q <= 1'b1; // RULE23
                    if (!stall && hold_q == 4'h0) begin
                        if (sto_q && !ack_phase_q)
                            st_q <= SMBCC_STOP; // RULE14
                        else if (tx_q && !ack_phase_q)
                            sda_drv_q <= ~tx_byte_i[7 - bit_q[2:0]];
                        if (!(sto_q && !ack_phase_q) && tick)
                            st_q <= SMBCC_BIT_HI;
                    end
                end
                SMBCC_BIT_HI: begin
                    scl_drv_q <= 1'b0;
                    if (tick && line.scl) begin
                        st_q <= SMBCC_BIT_LO;
                        hold_q <= setup_min; // RULE5
                    end
                end
                SMBCC_BIT_LO: begin
                    scl_drv_q <= 1'b1;
                    if (tick && hold_q == 4'h0)
                        st_q <= SMBCC_WAIT;
                end
                SMBCC_STOP: begin
                    sda_drv_q <= 1'b1;
                    scl_drv_q <= 1'b0;
                    if (tick && line.scl) begin
                        sda_drv_q <= 1'b0;
                        // pending start follows the stop
                        st_q <= SMBCC_IDLE; // RULE15
                    end else if (tick && !line.scl) begin
                        st_q <= SMBCC_IDLE; // RULE21
                    end
                end
                default: st_q <= SMBCC_IDLE;
            endcase
            if (ev_arb) begin
                st_q <= SMBCC_IDLE;
                sda_drv_q <= 1'b0;
                scl_drv_q <= 1'b0;
            end
        end
    end
endmodule

// file: smbcc_sva.sv
// checker: port-level assertions for the smbus control block
`timescale 1ns/100ps
module smbcc_sva
    import smbcc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_rdata_o,
    // timer 3 control
    input wire logic t3_split_i,
    input wire logic t3_reload_o,
    input wire logic t3_reload_hi_o,
    // bus pins
    input wire logic scl_i,
    input wire logic scl_oe_o,
    input wire logic sda_oe_o
);
    // shadow of the configuration register, rebuilt from the write port
    logic [7:0] cfg_q;
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cfg_q <= CFG_RST;
        end else if (sfr_wr_i && sfr_addr_i == CFG_ADDR) begin
            cfg_q <= sfr_wdata_i;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    reload_pair_a: assert property (
        t3_reload_o |-> t3_reload_hi_o && !t3_split_i)
        else $error("whole timer reload while split");
    toe_off_a: assert property (
        !cfg_q[CFG_TOE] |-> !t3_reload_hi_o)
        else $error("timer reload without timeout enable");
    scl_low_a: assert property (
        (!scl_i)[*5] |-> !t3_reload_hi_o)
        else $error("timer reload while scl low");
    scl_high_a: assert property (
        (scl_i && cfg_q[CFG_EN] && cfg_q[CFG_TOE] && !t3_split_i)[*5]
        |-> t3_reload_o) else $error("no timer reload while scl high");
    unmapped_rd_a: assert property (
        sfr_rd_i && sfr_addr_i != CFG_ADDR && sfr_addr_i != CTL_ADDR
        |=> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
    cfg_rd_a: assert property (
        sfr_rd_i && !sfr_wr_i && sfr_addr_i == CFG_ADDR |=>
        {sfr_rdata_o[7:6], sfr_rdata_o[4:0]} ==
        $past({cfg_q[7:6], cfg_q[4:0]})) else $error("config readback");
    si_hold_a: assert property (
        sfr_wr_i && sfr_addr_i == CTL_ADDR && sfr_wdata_i[CTL_SI] &&
        cfg_q[CFG_EN] |-> ##[1:4] scl_oe_o)
        else $error("scl not held low with flag set");
    disabled_a: assert property (
        (!cfg_q[CFG_EN])[*2] |-> !scl_oe_o && !sda_oe_o)
        else $error("pins driven while disabled");
    hold_norm_a: assert property (
        $rose(scl_oe_o) && !cfg_q[CFG_EXTH] |-> $stable(sda_oe_o)[*3])
        else $error("sda hold too short");
    hold_ext_a: assert property (
        $rose(scl_oe_o) && cfg_q[CFG_EXTH] |-> $stable(sda_oe_o)[*8])
        else $error("extended sda hold too short");
    cover property (scl_oe_o ##1 !scl_oe_o);
    cover property (t3_reload_hi_o && !t3_reload_o);
    cover property (sfr_rd_i && sfr_addr_i == CFG_ADDR);
    cover property (sda_oe_o && scl_oe_o);
endmodule

bind smbcc_top smbcc_sva u_sva (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o), .t3_split_i(t3_split_i),
    .t3_reload_o(t3_reload_o), .t3_reload_hi_o(t3_reload_hi_o),
    .scl_i(scl_i), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o)
);

// file: smbcc_peer.sv
// partner: another bus device making conditions on the open-drain lines
`timescale 1ns/100ps
module smbcc_peer (
    // resolved clock line
    input wire logic scl_i,
    // open-drain pulls, high pulls the line low
    output logic scl_pull_o,
    output logic sda_pull_o
);
    initial begin
        scl_pull_o = 1'b0;
        sda_pull_o = 1'b0;
    end
    // start: sda falls while scl is high
    task automatic start_cond();
        sda_pull_o = 1'b1;
        #83;
    endtask
    // stop: sda rises while scl is high
    task automatic stop_cond();
        scl_pull_o = 1'b1;
        sda_pull_o = 1'b1;
        #80;
        scl_pull_o = 1'b0;
        while (scl_i !== 1'b1) #10;
        #80;
        sda_pull_o = 1'b0;
        #80;
    endtask
    // both lines high again without a stop condition
    task automatic quiet_release();
        scl_pull_o = 1'b1;
        #80;
        sda_pull_o = 1'b0;
        #80;
        scl_pull_o = 1'b0;
        while (scl_i !== 1'b1) #10;
        #80;
    endtask
    task automatic hold_scl(input logic low);
        scl_pull_o = low;
        #80;
    endtask
    // eight data clocks, msb first; ends with scl held low before ack
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            scl_pull_o = 1'b1;
            sda_pull_o = !b[i];
            #80;
            scl_pull_o = 1'b0;
            #80;
        end
        scl_pull_o = 1'b1;
        sda_pull_o = 1'b0;
        #80;
    endtask
    // ninth clock once the device lets scl go
    task automatic ack_clock();
        scl_pull_o = 1'b0;
        while (scl_i !== 1'b1) #10;
        #80;
        scl_pull_o = 1'b1;
        #80;
    endtask
endmodule

// file: smbcc_top_tb_top.sv
// testbench: registers, timer 3 control, flag hold and bus timeouts
`timescale 1ns/100ps
`define CHK(g, e) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("wrong value at %0t: got %h expected %h", $time, g, e); \
    end \
end
module smbcc_top_tb_top
    import smbcc_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] ovf = 4'h0;
    logic split = 1'b0;
    logic [7:0] rdata;
    logic reload, reload_hi, scl_oe, sda_oe, scl_pull, sda_pull;
    logic [7:0] rx_byte;
    logic rx_valid, scl_lo, sda_lo;
    int rx_pulses = 0;
    wire logic scl_w = !(scl_oe || scl_pull);
    wire logic sda_w = !(sda_oe || sda_pull);
    int err_count = 0;
    int comparisons = 0;
    always #10 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        if (rx_valid)
            rx_pulses++;
    end
    smbcc_top dut (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_wr_i(wr),
        .sfr_rd_i(rd), .sfr_rdata_o(rdata),
        .tx_byte_i(8'h00), .tx_loaded_i(1'b0), .own_addr_i(8'ha0),
        .rx_byte_o(rx_byte), .rx_byte_valid_o(rx_valid),
        .t0_ovf_i(ovf[0]), .t1_ovf_i(ovf[1]), .t2h_ovf_i(ovf[2]),
        .t2l_ovf_i(ovf[3]), .t3_split_i(split),
        .t3_reload_o(reload), .t3_reload_hi_o(reload_hi),
        .scl_i(scl_w), .scl_o(scl_lo), .scl_oe_o(scl_oe),
        .sda_i(sda_w), .sda_o(sda_lo), .sda_oe_o(sda_oe)
    );
    smbcc_peer peer (
        .scl_i(scl_w), .scl_pull_o(scl_pull), .sda_pull_o(sda_pull)
    );
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk_sys_i);
        #2;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        step();
        addr = a;
        wdata = d;
        wr = 1'b1;
        step();
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        step();
        addr = a;
        rd = 1'b1;
        step();
        rd = 1'b0;
        d = rdata;
    endtask
    task automatic tick(input logic [3:0] sel, input int n);
        repeat (n) begin
            step();
            ovf = ovf | sel;
            step();
            ovf = ovf & ~sel;
            step(2);
        end
    endtask
    task automatic test_regs();
        logic [7:0] v;
        rd_reg(CFG_ADDR, v);
        `CHK(v, CFG_RST)
        rd_reg(CTL_ADDR, v);
        `CHK(v, CTL_RST)
        rd_reg(8'h55, v);
        `CHK(v, 8'h00)
        wr_reg(CFG_ADDR, 8'hff);
        rd_reg(CFG_ADDR, v);
        `CHK(v, 8'hdf)
        wr_reg(CFG_ADDR, 8'h00);
    endtask
    task automatic test_timer3();
        wr_reg(CFG_ADDR, 8'h88);
        step(6);
        `CHK({reload, reload_hi}, 2'b11)
        split = 1'b1;
        step();
        `CHK({reload, reload_hi}, 2'b01)
        peer.hold_scl(1'b1);
        step(4);
        `CHK({reload, reload_hi}, 2'b00)
        // timeout service: disable and re-enable the interface
        wr_reg(CFG_ADDR, 8'h08);
        wr_reg(CFG_ADDR, 8'h88);
        `CHK({reload, reload_hi}, 2'b00)
        peer.hold_scl(1'b0);
        split = 1'b0;
        wr_reg(CFG_ADDR, 8'h80);
        step(6);
        `CHK({reload, reload_hi}, 2'b00)
    endtask
    task automatic test_si();
        logic [7:0] v;
        for (int e = 0; e < 2; e++) begin
            wr_reg(CFG_ADDR, {1'b1, 2'b00, e[0], 4'h0});
            wr_reg(CTL_ADDR, 8'h01);
            step(4);
            rd_reg(CTL_ADDR, v);
            `CHK(v[CTL_SI], 1'b1)
            `CHK({scl_oe, scl_w}, 2'b10)
            `CHK({scl_lo, sda_lo}, 2'b00)
            wr_reg(CTL_ADDR, 8'h00);
            step(4);
            `CHK(scl_oe, 1'b0)
        end
    endtask
    task automatic test_stop();
        logic [7:0] v;
        wr_reg(CFG_ADDR, 8'h80);
        peer.start_cond();
        rd_reg(CFG_ADDR, v);
        `CHK(v[CFG_BUSY], 1'b1)
        peer.stop_cond();
        step(4);
        rd_reg(CFG_ADDR, v);
        `CHK(v[CFG_BUSY], 1'b0)
    endtask
    task automatic test_free();
        logic [7:0] v;
        logic [3:0] sel;
        for (int cs = 0; cs < 4; cs++) begin
            // unselected sources overflow every cycle and must not count
            sel = 4'h1 << cs;
            ovf = ~sel;
            wr_reg(CFG_ADDR, 8'h84 | 8'(cs));
            peer.start_cond();
            peer.quiet_release();
            tick(sel, 10);
            rd_reg(CFG_ADDR, v);
            `CHK(v[CFG_BUSY], 1'b1)
            tick(sel, 1);
            rd_reg(CFG_ADDR, v);
            `CHK(v[CFG_BUSY], 1'b0)
        end
        ovf = 4'h0;
    endtask
    task automatic test_rx();
        logic [7:0] v;
        wr_reg(CFG_ADDR, 8'h80);
        peer.start_cond();
        peer.send_byte(8'ha0);
        step(4);
        `CHK(rx_byte, 8'ha0)
        `CHK(rx_pulses, 1)
        `CHK(sda_oe, 1'b0)
        `CHK(scl_oe, 1'b1)
        rd_reg(CTL_ADDR, v);
        `CHK(v[CTL_ACK_REQUEST], 1'b1)
        `CHK(v[CTL_SI], 1'b1)
        wr_reg(CTL_ADDR, 8'h03);
        step(2);
        `CHK({sda_oe, scl_oe}, 2'b11)
        wr_reg(CTL_ADDR, 8'h02);
        step(2);
        `CHK(scl_oe, 1'b0)
        peer.ack_clock();
        step(4);
        rd_reg(CTL_ADDR, v);
        `CHK({v[CTL_ACK_REQUEST], sda_oe}, 2'b00)
        peer.stop_cond();
        step(4);
        rd_reg(CTL_ADDR, v);
        `CHK({v[CTL_STO], v[CTL_SI]}, 2'b11)
        wr_reg(CTL_ADDR, 8'h00);
    endtask
    task automatic summarize();
        if (err_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys_i);
        #2;
        srst_i = 1'b0;
        test_regs();
        test_timer3();
        test_si();
        test_stop();
        test_free();
        test_rx();
        summarize();
    end
    initial begin
        #400000;
        err_count++;
        summarize();
    end
endmodule
